// ===== pkg/dbsp_defines.svh
`ifndef DBSP_DEFINES_SVH
`define DBSP_DEFINES_SVH
// address width: 1M two-word locations (x18), use 19 for the x36 variant
`define DBSP_ADDR_W 20
// word width: 18 or 36
`define DBSP_DATA_W 18
// width of one byte lane including its ninth bit
`define DBSP_LANE_W 9
// number of byte lanes per word
`define DBSP_LANES 2
// depth of the write-log buffer
`define DBSP_FIFO_DEPTH 16
// read latency in input clock cycles with the pll running and in legacy mode
`define DBSP_LAT_PLL 2
`define DBSP_LAT_LEGACY 1
`endif

// ===== pkg/dbsp_pkg.sv
`include "dbsp_defines.svh"
package dbsp_pkg;
  // one completed write burst as seen on the pins
  typedef struct packed {
    logic [`DBSP_ADDR_W-1:0] addr;
    logic [`DBSP_LANES-1:0] mask0_n;
    logic [`DBSP_LANES-1:0] mask1_n;
    logic [`DBSP_DATA_W-1:0] d0;
    logic [`DBSP_DATA_W-1:0] d1;
  } dbsp_wrec_t;

  // state clocked by the positive input clock
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] pll_sync;
    logic tog;
    logic wr_pend;
    logic [`DBSP_ADDR_W-1:0] wr_addr;
    logic v1;
    logic v2;
    logic [`DBSP_DATA_W-1:0] s2d0;
    logic [`DBSP_DATA_W-1:0] s2d1;
    logic vk;
    logic [`DBSP_DATA_W-1:0] q0;
    logic [`DBSP_DATA_W-1:0] hold1;
    logic drop;
  } dbsp_kst_t;

  // state clocked by the negative input clock
  typedef struct packed {
    logic tog;
    logic vkn;
    logic [`DBSP_DATA_W-1:0] q1;
    logic [`DBSP_DATA_W-1:0] wd0;
    logic [`DBSP_LANES-1:0] wm0_n;
  } dbsp_nst_t;
endpackage : dbsp_pkg

// ===== src/dbsp_fifo.sv
`include "dbsp_defines.svh"
module dbsp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `DBSP_FIFO_DEPTH
) (
  input wire logic wr_clk_in, // filling side clock
  input wire logic wr_rst_in, // filling side reset, sync high
  input wire logic wr_valid_in, // entry offered
  output logic wr_ready_out, // room for an entry
  input wire logic [W-1:0] wr_data_in, // entry
  input wire logic rd_clk_in, // draining side clock
  input wire logic rd_rst_in, // draining side reset, sync high
  output logic rd_valid_out, // entry available
  input wire logic rd_ready_in, // entry taken
  output logic [W-1:0] rd_data_out // entry, from a register
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wbin_r, wgray_r, rg_s1_r, rg_s2_r;
  logic [AW:0] rbin_r, rgray_r, wg_s1_r, wg_s2_r;
  logic out_v_r;
  logic [W-1:0] out_d_r;
  logic full, empty, push, load;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  // full when write gray equals read gray with the two top bits inverted
  assign full = wgray_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
  assign empty = rgray_r == wg_s2_r;
  assign push = wr_valid_in && !full;
  assign load = !empty && (!out_v_r || rd_ready_in);
  assign wr_ready_out = !full;
  assign rd_valid_out = out_v_r;
  assign rd_data_out = out_d_r;

  // filling side: only gray pointers cross, so a torn sample is off by one at most
  always_ff @(posedge wr_clk_in)
  begin
    if (wr_rst_in)
    begin
      wbin_r <= '0;
      wgray_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end
    else
    begin
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
      if (push)
      begin
        wbin_r <= wbin_r + 1'b1;
        wgray_r <= to_gray(wbin_r + 1'b1);
      end
    end
  end

  // storage has no reset
  always_ff @(posedge wr_clk_in)
  begin
    if (push)
      mem[wbin_r[AW-1:0]] <= wr_data_in;
  end

  // draining side with a registered output stage
  always_ff @(posedge rd_clk_in)
  begin
    if (rd_rst_in)
    begin
      rbin_r <= '0;
      rgray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
      out_v_r <= 1'b0;
      out_d_r <= '0;
    end
    else
    begin
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
      out_v_r <= load || (out_v_r && !rd_ready_in);
      if (load)
      begin
        out_d_r <= mem[rbin_r[AW-1:0]];
        rbin_r <= rbin_r + 1'b1;
        rgray_r <= to_gray(rbin_r + 1'b1);
      end
    end
  end
endmodule : dbsp_fifo

// ===== src/dbsp_port.sv
// Function
// - a lane whose mask is high keeps its stored byte unchanged
// - mask 0 gates data bits 8..0, mask 1 gates bits 17..9
// - each mask is captured on the same edge as its data beat
// - one shared address bus, captured on positive clock rise at issue
// - address selects one two-word location held in two arrays
// - with issue strobe low, rw high means read, low means write
// - read beat valid marks read beats, aligned with the echo clock
// - positive clock rise captures inputs and launches the first read beat
// - negative clock rise captures first write beat, launches second read beat
// - free-running echo clock pair follows the positive input clock
// - issue strobe low starts a transaction of exactly two words
// - data pins are released whenever no read beat is driven
// - pll enabled: read latency two cycles; disabled: one cycle
`include "dbsp_defines.svh"
module dbsp_port #(
  parameter int ADDR_W = `DBSP_ADDR_W,
  parameter int DATA_W = `DBSP_DATA_W,
  parameter int LOG_DEPTH = `DBSP_FIFO_DEPTH
) (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_in, // system reset, sync high
  input wire logic k_clk_in, // positive input clock
  input wire logic k_n_clk_in, // negative input clock
  input wire logic issue_strobe_n_in, // transaction issue, low
  input wire logic rw_in, // high read, low write
  input wire logic [ADDR_W-1:0] addr_in, // shared address
  input wire logic [DATA_W-1:0] dq_in, // data pins, input side
  output logic [DATA_W-1:0] dq_out, // data pins, output side
  output logic dq_oe_out, // data pins driven
  input wire logic [`DBSP_LANES-1:0] lane_write_mask_n_in, // lane masks, low
  input wire logic pll_disable_n_in, // high pll mode, low legacy
  output logic echo_clk_out, // echo clock
  output logic echo_clk_n_out, // inverted echo clock
  output logic read_beat_valid_out, // read beat valid
  output logic log_ready_out, // write log has room (link side)
  output logic log_drop_out, // write burst lost to a full log
  output logic log_valid_out, // write record available
  input wire logic log_ready_in, // write record taken
  output dbsp_pkg::dbsp_wrec_t log_data_out // write record
);
  dbsp_pkg::dbsp_kst_t k_r, k_nxt;
  dbsp_pkg::dbsp_nst_t n_r, n_nxt;
  dbsp_pkg::dbsp_wrec_t rec;
  logic [DATA_W-1:0] arr0 [2**ADDR_W];
  logic [DATA_W-1:0] arr1 [2**ADDR_W];
  logic [DATA_W-1:0] rd0_r, rd1_r;
  logic link_rst, pll_on, issue, rd_go, wr_go, commit, launch, sel, fifo_ready;
  logic [DATA_W-1:0] peek0, peekw;
  // the record keeps the full address width even when the arrays are built smaller
  localparam int WA = `DBSP_ADDR_W;
  // array index cut to the depth actually built
  logic [ADDR_W-1:0] wr_idx;
  assign wr_idx = k_r.wr_addr[ADDR_W-1:0];

  // lane merge used for both words of a burst
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w, input logic [DATA_W-1:0] new_w,
                                              input logic [`DBSP_LANES-1:0] mask_n);
    merge = old_w;
    for (int i = 0; i < `DBSP_LANES; i++)
    begin
      if (!mask_n[i])
        merge[i*`DBSP_LANE_W +: `DBSP_LANE_W] = new_w[i*`DBSP_LANE_W +: `DBSP_LANE_W];
    end
  endfunction : merge

  assign link_rst = k_r.rst_sync[1];
  assign pll_on = k_r.pll_sync[1];
  assign issue = !issue_strobe_n_in;
  assign rd_go = issue && rw_in;
  assign wr_go = issue && !rw_in;
  assign commit = k_r.wr_pend;
  assign launch = pll_on ? k_r.v2 : k_r.v1;
  assign peek0 = arr0[addr_in];
  assign peekw = arr0[wr_idx];

  // write record: first beat from the negative clock, second straight off the pins
  always_comb
  begin
    rec.addr = k_r.wr_addr;
    rec.mask0_n = n_r.wm0_n;
    rec.mask1_n = lane_write_mask_n_in;
    rec.d0 = n_r.wd0;
    rec.d1 = dq_in;
  end

  // positive clock domain next state
  always_comb
  begin
    k_nxt = k_r;
    k_nxt.rst_sync = {k_r.rst_sync[0], rst_in};
    k_nxt.pll_sync = {k_r.pll_sync[0], pll_disable_n_in};
    if (link_rst)
    begin
      k_nxt.tog = 1'b0;
      k_nxt.wr_pend = 1'b0;
      k_nxt.wr_addr = '0;
      k_nxt.v1 = 1'b0;
      k_nxt.v2 = 1'b0;
      k_nxt.s2d0 = '0;
      k_nxt.s2d1 = '0;
      k_nxt.vk = 1'b0;
      k_nxt.q0 = '0;
      k_nxt.hold1 = '0;
      k_nxt.drop = 1'b0;
    end
    else
    begin
      k_nxt.tog = !k_r.tog;
      k_nxt.wr_pend = wr_go;
      if (wr_go)
        k_nxt.wr_addr = WA'(addr_in);
      k_nxt.v1 = rd_go;
      k_nxt.v2 = k_r.v1;
      k_nxt.s2d0 = rd0_r;
      k_nxt.s2d1 = rd1_r;
      // one extra stage when the pll is running
      k_nxt.vk = launch;
      if (launch)
      begin
        k_nxt.q0 = pll_on ? k_r.s2d0 : rd0_r;
        k_nxt.hold1 = pll_on ? k_r.s2d1 : rd1_r;
      end
      // the controller cannot be stalled, so a full log loses the record
      k_nxt.drop = commit && !fifo_ready;
    end
  end

  always_ff @(posedge k_clk_in)
  begin
    k_r <= k_nxt;
  end

  // core arrays: read-before-write, so a read on the commit edge sees old data
  always_ff @(posedge k_clk_in)
  begin
    if (commit)
    begin
      arr0[wr_idx] <= merge(arr0[wr_idx], n_r.wd0, n_r.wm0_n);
      arr1[wr_idx] <= merge(arr1[wr_idx], dq_in, lane_write_mask_n_in);
    end
    if (rd_go)
    begin
      rd0_r <= arr0[addr_in];
      rd1_r <= arr1[addr_in];
    end
  end

  // negative clock domain: second read beat and first write beat
  always_comb
  begin
    n_nxt = n_r;
    if (link_rst)
    begin
      n_nxt.tog = 1'b0;
      n_nxt.vkn = 1'b0;
      n_nxt.q1 = '0;
      n_nxt.wd0 = '0;
      n_nxt.wm0_n = '1;
    end
    else
    begin
      n_nxt.tog = k_r.tog;
      n_nxt.vkn = k_r.vk;
      if (k_r.vk)
        n_nxt.q1 = k_r.hold1;
      n_nxt.wd0 = dq_in;
      n_nxt.wm0_n = lane_write_mask_n_in;
    end
  end

  always_ff @(posedge k_n_clk_in)
  begin
    n_r <= n_nxt;
  end

  // toggle pair gives the phase: high after a positive rise, low after a negative rise
  assign sel = k_r.tog ^ n_r.tog;
  assign echo_clk_out = sel;
  assign echo_clk_n_out = !sel;
  assign dq_out = sel ? k_r.q0 : n_r.q1;
  assign read_beat_valid_out = sel ? k_r.vk : n_r.vkn;
  assign dq_oe_out = read_beat_valid_out;
  assign log_ready_out = fifo_ready;
  assign log_drop_out = k_r.drop;

  // write log towards the system side
  dbsp_fifo #(
    .W($bits(dbsp_pkg::dbsp_wrec_t)),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .wr_clk_in(k_clk_in),
    .wr_rst_in(link_rst),
    .wr_valid_in(commit),
    .wr_ready_out(fifo_ready),
    .wr_data_in(rec),
    .rd_clk_in(sys_clk_in),
    .rd_rst_in(rst_in),
    .rd_valid_out(log_valid_out),
    .rd_ready_in(log_ready_in),
    .rd_data_out(log_data_out)
  );

  // link state is unknown until the synchroniser has filled, so the pin reset masks the checks as well
  // checks on the positive clock
  AST_LAT_PLL: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    rd_go && pll_on |=> k_r.v1 ##1 k_r.v2 ##1 k_r.vk)
    else $error("pll mode read not launched two cycles after issue");
  AST_LAT_LEGACY: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    rd_go && !pll_on |=> k_r.v1 ##1 k_r.vk)
    else $error("legacy read not launched one cycle after issue");
  AST_VALID_CAUSE: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    k_r.vk |-> (pll_on && $past(rd_go, 3)) || (!pll_on && $past(rd_go, 2)))
    else $error("read beat valid without a matching read");
  AST_READ_DATA: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    rd_go && pll_on |-> ##3 k_r.q0 == $past(peek0, 3))
    else $error("first read beat does not match stored word");
  AST_ISSUE_WR: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    wr_go |=> k_r.wr_pend && k_r.wr_addr == $past(addr_in))
    else $error("write address not captured at issue");
  AST_LANE_WRITE: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    commit && !n_r.wm0_n[0] |=> arr0[$past(wr_idx)][8:0] == $past(n_r.wd0[8:0]))
    else $error("enabled lane 0 not stored");
  AST_LANE_KEEP: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    commit && n_r.wm0_n[0] |=> arr0[$past(wr_idx)][8:0] == $past(peekw[8:0]))
    else $error("masked lane 0 was altered");
  AST_LANE1_BEAT2: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    commit && !lane_write_mask_n_in[1] |=> arr1[$past(wr_idx)][17:9] == $past(dq_in[17:9]))
    else $error("second beat lane 1 not stored with its own mask");
  AST_ECHO_LOW: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    $past(link_rst, 2) || !echo_clk_out)
    else $error("echo clock not low before positive rise");
  // sampled here the pins show the second beat, which must follow the first
  AST_OE_BEAT: assert property (@(posedge k_clk_in) disable iff (rst_in || link_rst)
    dq_oe_out == k_r.vk && read_beat_valid_out == k_r.vk)
    else $error("second beat drive differs from first beat valid");

  // checks on the negative clock
  AST_ECHO_HIGH: assert property (@(posedge k_n_clk_in) disable iff (rst_in || link_rst)
    $past(link_rst) || echo_clk_out)
    else $error("echo clock not high before negative rise");

  COV_READ_PLL: cover property (@(posedge k_clk_in) disable iff (link_rst) rd_go && pll_on ##3 k_r.vk);
  COV_READ_LEGACY: cover property (@(posedge k_clk_in) disable iff (link_rst) rd_go && !pll_on ##2 k_r.vk);
  COV_WRITE: cover property (@(posedge k_clk_in) disable iff (link_rst) wr_go ##1 commit);
  COV_BACK_TO_BACK: cover property (@(posedge k_clk_in) disable iff (link_rst) rd_go ##1 rd_go);
  COV_LOG_DROP: cover property (@(posedge k_clk_in) disable iff (link_rst) commit && !fifo_ready);
endmodule : dbsp_port

// ===== verif/dbsp_ctrl_model.sv
`include "dbsp_defines.svh"
// memory controller on the far side of the pins
module dbsp_ctrl_model (
  input wire logic k_clk_in, // positive input clock
  input wire logic [`DBSP_DATA_W-1:0] dq_wire_in, // resolved data wire
  input wire logic valid_in, // read beat valid from the device
  input wire logic echo_in, // echo clock from the device
  output logic issue_n_out, // issue strobe, low
  output logic rw_out, // high read, low write
  output logic [7:0] addr_out, // shared address
  output logic [`DBSP_DATA_W-1:0] dq_drv_out, // data driven by the controller
  output logic [`DBSP_LANES-1:0] mask_n_out // lane masks, low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    issue_n_out = 1'b1;
    rw_out = 1'b0;
    addr_out = 8'h00;
    dq_drv_out = 18'h00000;
    mask_n_out = 2'h3;
  end
  // write: beat0 with the negative clock after issue, beat1 with the next positive rise
  task automatic wr(input logic [7:0] a, input logic [17:0] d0, d1, input logic [1:0] m0, m1);
    @(negedge k_clk_in);
    #1;
    issue_n_out = 1'b0;
    rw_out = 1'b0;
    addr_out = a;
    @(posedge k_clk_in);
    #1;
    issue_n_out = 1'b1;
    addr_out = ~a;
    dq_drv_out = d0;
    mask_n_out = m0;
    @(negedge k_clk_in);
    #1;
    dq_drv_out = d1;
    mask_n_out = m1;
    @(posedge k_clk_in);
    #1;
    // released lines show the inverse so stale data cannot pass for a match
    dq_drv_out = ~d1;
    mask_n_out = ~m1;
  endtask : wr
  // read: sample each beat 2 ns after its launching edge
  task automatic rd(input logic [7:0] a, input int lat, output logic [17:0] w0, w1, output logic v0, v1, e0);
    @(negedge k_clk_in);
    #1;
    issue_n_out = 1'b0;
    rw_out = 1'b1;
    addr_out = a;
    @(posedge k_clk_in);
    #1;
    issue_n_out = 1'b1;
    rw_out = 1'b0;
    addr_out = ~a;
    dq_drv_out = ~dq_drv_out;
    repeat (lat) @(posedge k_clk_in);
    #2;
    w0 = dq_wire_in;
    v0 = valid_in;
    e0 = echo_in;
    @(negedge k_clk_in);
    #2;
    w1 = dq_wire_in;
    v1 = valid_in;
    @(posedge k_clk_in);
    #2;
  endtask : rd
endmodule : dbsp_ctrl_model

// ===== verif/dbsp_port_bench.sv
`include "dbsp_defines.svh"
module dbsp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, k_clk = 1'b0, rst = 1'b1, pll_n = 1'b1, log_rdy = 1'b0, hold_log = 1'b1;
  logic issue_n, rw, dq_oe, echo, echo_n, valid, log_rdy_o, log_drop, log_valid;
  logic [7:0] addr;
  logic [17:0] dq_o, dq_drv, mem0 [16], mem1 [16];
  logic [1:0] mask_n;
  dbsp_pkg::dbsp_wrec_t log_data, exp_q [$];
  int seed = 32'h1c51c509, n_mismatch = 0, n_tests = 0, n_drop = 0, cyc = 0;
  wire logic [17:0] dq_w = dq_oe ? dq_o : dq_drv;
  always #5 sys_clk = ~sys_clk;
  // link clock offset so its edges never line up with the system clock
  initial
  begin
    #3;
    forever #40 k_clk = ~k_clk;
  end
  dbsp_port #(.ADDR_W(8)) dut (.sys_clk_in(sys_clk), .rst_in(rst), .k_clk_in(k_clk), .k_n_clk_in(~k_clk),
    .issue_strobe_n_in(issue_n), .rw_in(rw), .addr_in(addr), .dq_in(dq_w), .dq_out(dq_o), .dq_oe_out(dq_oe),
    .lane_write_mask_n_in(mask_n), .pll_disable_n_in(pll_n), .echo_clk_out(echo), .echo_clk_n_out(echo_n),
    .read_beat_valid_out(valid), .log_ready_out(log_rdy_o), .log_drop_out(log_drop), .log_valid_out(log_valid),
    .log_ready_in(log_rdy), .log_data_out(log_data));
  dbsp_ctrl_model ctrl (.k_clk_in(k_clk), .dq_wire_in(dq_w), .valid_in(valid), .echo_in(echo),
    .issue_n_out(issue_n), .rw_out(rw), .addr_out(addr), .dq_drv_out(dq_drv), .mask_n_out(mask_n));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic cmp_w(input logic [17:0] got, exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_w
  task automatic cmp_rec(input dbsp_pkg::dbsp_wrec_t got, exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t log record got %h exp %h", $time, got, exp);
    end
  endtask : cmp_rec
  // a lane whose mask is high keeps the old byte
  function automatic logic [17:0] merge(input logic [17:0] o, n, input logic [1:0] m);
    merge = o;
    if (m[0] == 1'b0)
      merge[8:0] = n[8:0];
    if (m[1] == 1'b0)
      merge[17:9] = n[17:9];
  endfunction : merge
  task automatic do_wr(input logic [7:0] a, input logic [1:0] m0, m1);
    logic [17:0] d0, d1;
    d0 = 18'($random(seed));
    d1 = 18'($random(seed));
    exp_q.push_back({20'(a), m0, m1, d0, d1});
    mem0[a] = merge(mem0[a], d0, m0);
    mem1[a] = merge(mem1[a], d1, m1);
    ctrl.wr(a, d0, d1, m0, m1);
  endtask : do_wr
  task automatic do_rd(input logic [7:0] a, input int lat);
    logic [17:0] w0, w1;
    logic v0, v1, e0;
    ctrl.rd(a, lat, w0, w1, v0, v1, e0);
    cmp_w(w0, mem0[a], "beat0");
    cmp_w(w1, mem1[a], "beat1");
    cmp_w({v0, v1, valid}, 18'h6, "valid beats");
    cmp_w({e0, echo_n, echo}, 18'h5, "echo");
    cmp_w(dq_oe, 18'h0, "pins released");
  endtask : do_rd
  task automatic ops(input int n, input int lat);
    logic [7:0] a;
    for (int i = 0; i < n; i++)
    begin
      a = 8'($random(seed)) & 8'h0f;
      if ($random(seed) & 1)
        do_rd(a, lat);
      else
        do_wr(a, 2'($random(seed)), 2'($random(seed)));
    end
  endtask : ops
  // drained records must come in write order with the pin values
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (!rst && log_valid === 1'b1 && log_rdy)
      cmp_rec(log_data, exp_q.size() > 0 ? exp_q.pop_front() : '0);
    if (cyc == 60000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  always @(negedge sys_clk) log_rdy <= hold_log ? 1'b0 : 1'($random(seed));
  always @(posedge k_clk) if (log_drop === 1'b1) n_drop <= n_drop + 1;
  initial
  begin
    repeat (10) @(negedge k_clk);
    rst = 1'b0;
    hold_log = 1'b0;
    repeat (4) @(negedge k_clk);
    for (int a = 0; a < 16; a++) do_wr(8'(a), 2'h0, 2'h0);
    do_wr(8'h3, 2'h3, 2'h3);
    do_rd(8'h3, 2);
    do_wr(8'h3, 2'h2, 2'h1);
    do_rd(8'h3, 2);
    ops(40, 2);
    $display("test pll mode done");
    @(negedge k_clk);
    pll_n = 1'b0;
    repeat (4) @(negedge k_clk);
    ops(30, 1);
    $display("test legacy mode done");
    hold_log = 1'b1;
    repeat (100) @(negedge sys_clk);
    n_drop = 0;
    for (int i = 0; i < 20; i++) do_wr(8'(i & 15), 2'h0, 2'h0);
    cmp_w(18'(log_rdy_o), 18'h0, "log full flag");
    repeat (4) @(negedge k_clk);
    hold_log = 1'b0;
    for (int i = 0; i < 3000 && exp_q.size() > n_drop; i++) @(negedge sys_clk);
    cmp_w(18'(n_drop > 0), 18'h1, "drop seen");
    cmp_w(18'(exp_q.size()), 18'(n_drop), "kept records");
    $display("test log full done");
    conclude();
  end
endmodule : dbsp_port_bench
